// ==== bench/aur_receiver_chk.sv ====
// Port-level concurrent checks for the serial receiver
`timescale 1ns/10ps
module aur_receiver_chk (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_rx_pin_oe,
    input wire logic o_tx_pin,
    input wire logic o_tx_pin_oe,
    input wire logic o_rx_pending_flag,
    input wire logic o_irq
);
    logic dp_v; // Data phase under way
    logic dp_w; // Data phase is a write
    logic [7:0] dp_a; // Address of that data phase
    logic pe_s; // Shadow of port enable
    logic re_s; // Shadow of receive enable
    logic [2:0] ie_s; // Shadow of the interrupt enables
    logic rd_v; // Read data phase
    logic pop; // Read of the data buffer
    assign rd_v = dp_v & ~dp_w;
    assign pop = rd_v && (dp_a == aur_pkg::ADDR_RX_DATA_BUFFER);
    // Address and direction are sampled every cycle; dp_v is set only when the bus takes the transfer
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dp_v <= 1'b0;
            dp_w <= 1'b0;
            dp_a <= 8'h00;
        end else begin
            dp_v <= i_hsel & i_htrans[1] & i_hready;
            dp_w <= i_hwrite;
            dp_a <= i_haddr;
        end
    end
    // Shadows move on the same edge the design takes write data
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pe_s <= 1'b0;
            re_s <= 1'b0;
            ie_s <= 3'h0;
        end else if (dp_v && dp_w) begin
            if (dp_a == aur_pkg::ADDR_RX_STATUS_CONTROL) begin
                pe_s <= i_hwdata[aur_pkg::RS_PORT_EN];
                re_s <= i_hwdata[aur_pkg::RS_RX_EN];
            end
            if (dp_a == aur_pkg::ADDR_IRQ_CONTROL) begin
                ie_s <= i_hwdata[2:0];
            end
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Two-deep shadow history allows for the registered pin outputs
    property p_rx_in; o_rx_pin_oe == 1'b0; endproperty
    a_rx_in: assert property (p_rx_in) else $error("rx pin driven");
    property p_tx_out; pe_s && $past(pe_s) && $past(pe_s, 2)
        |-> o_tx_pin && o_tx_pin_oe; endproperty
    a_tx_out: assert property (p_tx_out) else $error("tx pin not serial output");
    property p_irq; o_irq |-> (&($past(ie_s)))
        && (o_rx_pending_flag || $past(o_rx_pending_flag)); endproperty
    a_irq: assert property (p_irq) else $error("irq without enables or pending");
    property p_pend_en; o_rx_pending_flag |-> $past(pe_s) && $past(re_s); endproperty
    a_pend_en: assert property (p_pend_en) else $error("pending while disabled");
    property p_pend_fall; $fell(o_rx_pending_flag) |-> $past(pop) || $past(pop, 2)
        || !pe_s || !re_s || !$past(pe_s) || !$past(re_s); endproperty
    a_pend_fall: assert property (p_pend_fall) else $error("pending cleared without read");
    property p_off_flags; rd_v && dp_a == aur_pkg::ADDR_RX_STATUS_CONTROL
        && !$past(pe_s) && !$past(pe_s, 2) |-> o_hrdata[2:1] == 2'b00; endproperty
    a_off_flags: assert property (p_off_flags) else $error("flags set with port off");
    property p_idle_off; rd_v && dp_a == aur_pkg::ADDR_BAUD_CONTROL
        && !$past(pe_s) && !$past(pe_s, 2) |-> o_hrdata[aur_pkg::BC_IDLE]; endproperty
    a_idle_off: assert property (p_idle_off) else $error("not idle with port off");
    property p_data_hi; pop |-> o_hrdata[31:8] == 24'h0; endproperty
    a_data_hi: assert property (p_data_hi) else $error("data upper bits set");
endmodule // aur_receiver_chk
bind aur_receiver aur_receiver_chk aur_receiver_chk_i (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata), .o_rx_pin_oe(o_rx_pin_oe),
    .o_tx_pin(o_tx_pin), .o_tx_pin_oe(o_tx_pin_oe), .o_rx_pending_flag(o_rx_pending_flag),
    .o_irq(o_irq));

// ==== bench/aur_tx_model.sv ====
// Remote serial transmitter model driving the shared receive line
`timescale 1ns/10ps
module aur_tx_model (
    input wire logic i_clk,
    output logic o_line
);
    // Line rests at mark level, as a pulled-up idle line does
    initial o_line = 1'b1;
    // Start bit, nb data bits first bit lowest, then stop level stp; b clocks a bit
    task automatic send(input logic [8:0] d, input int nb, input logic stp, input int b);
        for (int i = 0; i < nb + 2; i++) begin
            @(posedge i_clk);
            o_line <= (i == 0) ? 1'b0 : (i > nb) ? stp : d[i - 1];
            repeat (b - 1) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_line <= 1'b1; // Back to mark after the stop slot
    endtask
    // Short low pulse, far shorter than half a bit
    task automatic glitch(input int n);
        @(posedge i_clk);
        o_line <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_line <= 1'b1;
    endtask
endmodule // aur_tx_model

// ==== bench/tb_aur_receiver.sv ====
// Self-checking bench for the serial receiver and its line partner
`timescale 1ns/10ps
module tb_aur_receiver;
    localparam logic [7:0] BC = aur_pkg::ADDR_BAUD_CONTROL;
    localparam logic [7:0] DB = aur_pkg::ADDR_RX_DATA_BUFFER;
    localparam logic [7:0] RS = aur_pkg::ADDR_RX_STATUS_CONTROL;
    localparam logic [7:0] DL = aur_pkg::ADDR_DIVISOR_LOW_BYTE;
    localparam logic [7:0] TS = aur_pkg::ADDR_TX_STATUS_CONTROL;
    localparam logic [7:0] IC = aur_pkg::ADDR_IRQ_CONTROL;
    logic clk = 1'b0; // 100 MHz system clock
    logic nrst = 1'b0; // Active-low reset
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdv; // Bus read data and last value taken
    logic hrdy, hresp, line, rx_oe, tx, tx_oe, pend, irq;
    logic dir = 1'b1; // Pin direction, 1 means input
    logic gpio = 1'b0; // General-purpose latch
    int fails = 0, n_compared = 0, cyc = 0, seed = 32'hCC48D063;
    always #5 clk = ~clk;
    aur_receiver aur_receiver_i (.i_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_rx_pin(line), .o_rx_pin_oe(rx_oe), .o_tx_pin(tx), .o_tx_pin_oe(tx_oe),
        .i_pin_direction_bit(dir), .i_gpio_latch(gpio), .o_rx_pending_flag(pend), .o_irq(irq));
    aur_tx_model aur_tx_model_i (.i_clk(clk), .o_line(line));
    // Single place where the run ends
    task automatic give_verdict;
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One AHB-Lite single transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        rdv = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(rdv, e);
        chk(hresp, 1'b0);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bounded wait for the pending flag to reach e
    task automatic wpend(input logic e, input int n);
        for (int i = 0; i < n && pend !== e; i++) @(posedge clk);
        chk(pend, e);
    endtask
    // Character that must be taken in
    task automatic xfer(input logic [8:0] d, input int nb, input logic stp, input int bc);
        aur_tx_model_i.send(d, nb, stp, bc);
        wpend(1'b1, 12 * bc);
    endtask
    // Character that must be dropped
    task automatic quiet(input logic [8:0] d, input int nb, input int bc);
        aur_tx_model_i.send(d, nb, 1'b1, bc);
        settle(3 * bc);
        chk(pend, 1'b0);
    endtask
    // Expected status byte: control bits kept, flags {frame_error_flag, overrun, ninth}
    function automatic logic [31:0] rs(input logic [7:0] c, input logic [2:0] f);
        return {24'h0, c[7:3], f};
    endfunction
    // Hang guard; the whole plan needs well under this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict;
        end
    end
    initial begin
        logic [7:0] b;
        logic [7:0] v [3];
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rchk(BC, 32'h40);
        rchk(RS, 32'h0);
        rchk(8'h1C, 32'h0);
        // Port off: pin follows latch and direction
        for (int k = 0; k < 4; k++) begin
            {dir, gpio} <= 2'($random(seed));
            settle(3);
            chk({tx, tx_oe}, {gpio, ~dir});
        end
        bus(1'b1, TS, 8'h04);
        bus(1'b1, RS, 8'h80);
        settle(3);
        chk({tx, tx_oe}, 2'b11);
        bus(1'b1, IC, 8'h07);
        bus(1'b1, RS, 8'h90);
        // Random characters; first one sweeps the interrupt enables
        for (int k = 0; k < 4; k++) begin
            b = 8'($random(seed));
            xfer({1'b0, b}, 8, 1'b1, 16);
            rchk(RS, rs(8'h90, 3'b000));
            for (int m = 0; m < 8 && k == 0; m++) begin
                bus(1'b1, IC, 8'(m));
                settle(3);
                chk({pend, irq}, {1'b1, m == 7});
            end
            rchk(DB, {24'h0, b});
            settle(3);
            chk(pend, 1'b0);
        end
        // Three back to back with no reads: overrun
        for (int k = 0; k < 3; k++) begin
            v[k] = 8'($random(seed));
            aur_tx_model_i.send({1'b0, v[k]}, 8, 1'b1, 16);
        end
        settle(48);
        rchk(RS, rs(8'h90, 3'b010));
        rchk(DB, {24'h0, v[0]});
        rchk(DB, {24'h0, v[1]});
        quiet(9'h0A5, 8, 16);
        bus(1'b1, RS, 8'h80);
        bus(1'b1, RS, 8'h90);
        rchk(RS, rs(8'h90, 3'b000));
        // Framing error kept per entry, survives receiver off
        xfer(9'h03C, 8, 1'b0, 16);
        aur_tx_model_i.send(9'h0C3, 8, 1'b1, 16);
        settle(32);
        rchk(RS, rs(8'h90, 3'b100));
        bus(1'b1, RS, 8'h80);
        settle(3);
        chk(pend, 1'b0);
        rchk(RS, rs(8'h80, 3'b100));
        bus(1'b1, RS, 8'h90);
        rchk(DB, 32'h3C);
        rchk(RS, rs(8'h90, 3'b000));
        rchk(DB, 32'hC3);
        xfer(9'h055, 8, 1'b0, 16);
        bus(1'b1, RS, 8'h00);
        settle(2);
        rchk(RS, 32'h0);
        chk(pend, 1'b0);
        bus(1'b1, RS, 8'h80);
        bus(1'b1, RS, 8'h90);
        // Short low pulse is not a start bit
        aur_tx_model_i.glitch(5);
        settle(48);
        rchk(RS, rs(8'h90, 3'b000));
        fork
            xfer(9'h096, 8, 1'b1, 16);
            begin
                settle(60);
                rchk(BC, 32'h0);
            end
        join
        rchk(DB, 32'h96);
        // Slower rates: 32 and 64 clocks a bit
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, DL, 8'(1 - k));
            bus(1'b1, TS, k ? 8'h00 : 8'h04);
            b = 8'($random(seed));
            xfer({1'b0, b}, 8, 1'b1, 32 * (k + 1));
            rchk(DB, {24'h0, b});
        end
        bus(1'b1, TS, 8'h14);
        quiet({1'b0, b}, 8, 16);
        bus(1'b1, TS, 8'h04);
        // Nine-bit characters and address filtering
        bus(1'b1, RS, 8'hD0);
        xfer({1'b1, b}, 9, 1'b1, 16);
        rchk(RS, rs(8'hD0, 3'b001));
        rchk(DB, {24'h0, b});
        bus(1'b1, RS, 8'hD8);
        quiet({1'b0, b}, 9, 16);
        xfer({1'b1, ~b}, 9, 1'b1, 16);
        rchk(RS, rs(8'hD8, 3'b001));
        rchk(DB, {24'h0, ~b});
        bus(1'b1, RS, 8'hD0);
        xfer({1'b0, b}, 9, 1'b1, 16);
        rchk(RS, rs(8'hD0, 3'b000));
        rchk(DB, {24'h0, b});
        give_verdict;
    end
endmodule // tb_aur_receiver

// ==== shared/aur_pkg.sv ====
// Package of offsets, field positions, reset values and states for the receiver
package aur_pkg;
    // Register byte addresses (word aligned)
    localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_RX_DATA_BUFFER = 8'h04;
    localparam logic [7:0] ADDR_RX_STATUS_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_DIVISOR_LOW_BYTE = 8'h0C;
    localparam logic [7:0] ADDR_DIVISOR_HIGH_BYTE = 8'h10;
    localparam logic [7:0] ADDR_TX_STATUS_CONTROL = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h18;
    // rx_status_control fields
    localparam int RS_PORT_EN = 7;
    localparam int RS_NINE = 6;
    localparam int RS_RX_EN = 4;
    localparam int RS_ADDR_FILT = 3;
    localparam int RS_FRAME_ERROR_FLAG = 2;
    localparam int RS_OVR = 1;
    localparam int RS_NINTH = 0;
    // baud_control fields
    localparam int BC_IDLE = 6;
    localparam int BC_WIDE = 3;
    // tx_status_control fields
    localparam int TS_CLOCKED = 4;
    localparam int TS_HIGH_SPEED = 2;
    localparam int TS_TX_EMPTY = 1;
    // irq_control fields
    localparam int IC_RX_IE = 0;
    localparam int IC_PERIPH_IE = 1;
    localparam int IC_GLOBAL_IE = 2;
    // Reset values of writable bytes
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Oversampling
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
    localparam logic [3:0] FULL_BIT_TICKS = 4'hF;
    localparam logic [3:0] MAJ_A = 4'h7;
    localparam logic [3:0] MAJ_B = 4'h8;
    localparam logic [3:0] MAJ_C = 4'h9;
    localparam logic [1:0] PRESCALE_LOW_SPEED = 2'h3;
    // Receiver states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b10,
        ST_STOP = 2'b11
    } aur_state_t;
endpackage

// ==== verilog/aur_receiver.sv ====
// Asynchronous serial receiver with 16x oversampling, 2-deep FIFO and AHB-Lite registers
`timescale 1ns/10ps
module aur_receiver (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_rx_pin,
    output logic o_rx_pin_oe,
    output logic o_tx_pin,
    output logic o_tx_pin_oe,
    input wire logic i_pin_direction_bit,
    input wire logic i_gpio_latch,
    output logic o_rx_pending_flag,
    output logic o_irq
);
    // Writable control bytes
    logic [7:0] status_ctl_r;
    logic [7:0] baud_ctl_r;
    logic [7:0] tx_ctl_r;
    logic [7:0] div_lo_r;
    logic [7:0] div_hi_r;
    logic [2:0] irq_ctl_r;
    // Latched AHB address phase
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;
    // Baud generator
    logic [15:0] brg_cnt_r;
    logic [1:0] pre_cnt_r;
    logic tick_r;
    // Receive engine
    aur_pkg::aur_state_t state_r;
    logic [3:0] sub_r;
    logic [3:0] bit_idx_r;
    logic [8:0] shift_r;
    logic [2:0] votes_r;
    logic rx_prev_r;
    // FIFO of two entries: data, ninth bit, framing error
    logic [9:0] fifo_r [0:1];
    logic rd_ptr_r;
    logic wr_ptr_r;
    logic [1:0] count_r;
    logic overrun_r;
    logic frame_error_flag_hold_r;

    // Convenience decodes
    logic port_en;
    logic rx_en;
    logic active;
    logic addr_ok;
    logic pop;
    logic push;
    logic [9:0] head;
    logic majority;
    logic [15:0] divisor;
    logic div_write;
    logic [3:0] last_bit;
    logic stop_done;
    logic accept;

    assign port_en = status_ctl_r[aur_pkg::RS_PORT_EN];
    assign rx_en = status_ctl_r[aur_pkg::RS_RX_EN];
    assign active = port_en && rx_en && !tx_ctl_r[aur_pkg::TS_CLOCKED];
    assign addr_ok = (i_hsel && i_htrans[1] && i_hready);
    assign pop = rd_pend_r && (addr_r == aur_pkg::ADDR_RX_DATA_BUFFER)
        && (count_r != 2'h0);
    assign head = fifo_r[rd_ptr_r];
    // Wide divider optional; otherwise only the low byte counts
    assign divisor = baud_ctl_r[aur_pkg::BC_WIDE] ? {div_hi_r, div_lo_r} : {8'h00, div_lo_r};
    assign div_write = wr_pend_r && ((addr_r == aur_pkg::ADDR_DIVISOR_LOW_BYTE)
        || (addr_r == aur_pkg::ADDR_DIVISOR_HIGH_BYTE));
    // Two of three samples around the bit centre
    assign majority = (votes_r[0] & votes_r[1]) | (votes_r[0] & votes_r[2])
        | (votes_r[1] & votes_r[2]);
    assign last_bit = status_ctl_r[aur_pkg::RS_NINE] ? 4'h8 : 4'h7;
    assign stop_done = tick_r && (state_r == aur_pkg::ST_STOP)
        && (sub_r == aur_pkg::FULL_BIT_TICKS);
    // In nine-bit mode the address filter drops characters whose ninth bit is clear
    assign accept = !(status_ctl_r[aur_pkg::RS_ADDR_FILT] && status_ctl_r[aur_pkg::RS_NINE]
        && !shift_r[8]);
    assign push = stop_done && accept && !overrun_r && (count_r != 2'h2);

    // AHB-Lite address phase capture; single-cycle zero-wait answers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok && i_hwrite;
            rd_pend_r <= addr_ok && !i_hwrite;
            if (addr_ok) begin
                addr_r <= i_haddr;
            end
        end
    end

    // Control register writes; unmapped writes are ignored
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_ctl_r <= aur_pkg::RESET_BYTE;
            baud_ctl_r <= aur_pkg::RESET_BYTE;
            tx_ctl_r <= aur_pkg::RESET_BYTE;
            div_lo_r <= aur_pkg::RESET_BYTE;
            div_hi_r <= aur_pkg::RESET_BYTE;
            irq_ctl_r <= 3'h0;
        end else if (wr_pend_r) begin
            if (addr_r == aur_pkg::ADDR_RX_STATUS_CONTROL) begin
                // Status bits 2..0 are read-only
                status_ctl_r <= {i_hwdata[7:3], 3'h0};
            end else if (addr_r == aur_pkg::ADDR_BAUD_CONTROL) begin
                baud_ctl_r <= {4'h0, i_hwdata[aur_pkg::BC_WIDE], 3'h0};
            end else if (addr_r == aur_pkg::ADDR_TX_STATUS_CONTROL) begin
                tx_ctl_r <= {3'h0, i_hwdata[4], 1'b0, i_hwdata[2], 2'h0};
            end else if (addr_r == aur_pkg::ADDR_DIVISOR_LOW_BYTE) begin
                div_lo_r <= i_hwdata[7:0];
            end else if (addr_r == aur_pkg::ADDR_DIVISOR_HIGH_BYTE) begin
                div_hi_r <= i_hwdata[7:0];
            end else if (addr_r == aur_pkg::ADDR_IRQ_CONTROL) begin
                irq_ctl_r <= i_hwdata[2:0];
            end
        end
    end

    // Read data mux and bus response
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            o_hrdata <= 32'h0000_0000;
            if (addr_ok && !i_hwrite) begin
                if (i_haddr == aur_pkg::ADDR_RX_DATA_BUFFER) begin
                    o_hrdata <= {24'h00_0000, head[7:0]};
                end else if (i_haddr == aur_pkg::ADDR_RX_STATUS_CONTROL) begin
                    // Ninth and framing flags follow the oldest unread entry; ninth bit 0 when empty, framing flag held
                    o_hrdata <= {24'h00_0000, status_ctl_r[7:3],
                        frame_error_flag_hold_r, overrun_r, head[8] && (count_r != 2'h0)};
                end else if (i_haddr == aur_pkg::ADDR_BAUD_CONTROL) begin
                    o_hrdata <= {24'h00_0000, baud_ctl_r[7], (state_r == aur_pkg::ST_IDLE),
                        baud_ctl_r[5:0]};
                end else if (i_haddr == aur_pkg::ADDR_TX_STATUS_CONTROL) begin
                    o_hrdata <= {24'h00_0000, tx_ctl_r[7:2], 1'b1, tx_ctl_r[0]};
                end else if (i_haddr == aur_pkg::ADDR_DIVISOR_LOW_BYTE) begin
                    o_hrdata <= {24'h00_0000, div_lo_r};
                end else if (i_haddr == aur_pkg::ADDR_DIVISOR_HIGH_BYTE) begin
                    o_hrdata <= {24'h00_0000, div_hi_r};
                end else if (i_haddr == aur_pkg::ADDR_IRQ_CONTROL) begin
                    o_hrdata <= {29'h0000_0000, irq_ctl_r};
                end
            end
        end
    end

    // Baud generator: divisor+1 clocks per tick, /4 prescale in low speed
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            brg_cnt_r <= 16'h0000;
            pre_cnt_r <= 2'h0;
            tick_r <= 1'b0;
        end else if (!port_en || div_write) begin
            // Restart at once so a new rate applies immediately
            brg_cnt_r <= 16'h0000;
            pre_cnt_r <= 2'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (brg_cnt_r >= divisor) begin
                brg_cnt_r <= 16'h0000;
                if (tx_ctl_r[aur_pkg::TS_HIGH_SPEED]
                    || pre_cnt_r == aur_pkg::PRESCALE_LOW_SPEED) begin
                    pre_cnt_r <= 2'h0;
                    tick_r <= 1'b1;
                end else begin
                    pre_cnt_r <= pre_cnt_r + 2'h1;
                end
            end else begin
                brg_cnt_r <= brg_cnt_r + 16'h0001;
            end
        end
    end

    // Receive state machine, one step per 16x tick
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= aur_pkg::ST_IDLE;
            sub_r <= 4'h0;
            bit_idx_r <= 4'h0;
            shift_r <= 9'h000;
            votes_r <= 3'h0;
            rx_prev_r <= 1'b1;
        end else if (!active) begin
            state_r <= aur_pkg::ST_IDLE;
            sub_r <= 4'h0;
            rx_prev_r <= 1'b1;
        end else if (tick_r) begin
            rx_prev_r <= i_rx_pin;
            // Collect three samples around the centre
            if (sub_r == aur_pkg::MAJ_A) begin
                votes_r[0] <= i_rx_pin;
            end else if (sub_r == aur_pkg::MAJ_B) begin
                votes_r[1] <= i_rx_pin;
            end else if (sub_r == aur_pkg::MAJ_C) begin
                votes_r[2] <= i_rx_pin;
            end
            case (state_r)
                aur_pkg::ST_IDLE: begin
                    // High line is idle; falling edge starts a character
                    sub_r <= 4'h0;
                    if (rx_prev_r && !i_rx_pin) begin
                        state_r <= aur_pkg::ST_START;
                        sub_r <= 4'h1;
                    end
                end
                aur_pkg::ST_START: begin
                    if (sub_r == aur_pkg::HALF_BIT_TICKS && i_rx_pin) begin
                        // High again at the centre: a glitch, dropped without error
                        state_r <= aur_pkg::ST_IDLE;
                        sub_r <= 4'h0;
                    end else if (sub_r == aur_pkg::FULL_BIT_TICKS) begin
                        // Run to the end of the start bit so data votes land mid-bit
                        state_r <= aur_pkg::ST_DATA;
                        sub_r <= 4'h0;
                        bit_idx_r <= 4'h0;
                        shift_r <= 9'h000;
                    end else begin
                        sub_r <= sub_r + 4'h1;
                    end
                end
                aur_pkg::ST_DATA: begin
                    // sub 0 is a bit start edge; votes at 7,8,9 bracket the centre
                    if (sub_r == aur_pkg::FULL_BIT_TICKS) begin
                        // Shift right so the first bit ends in bit 0
                        if (last_bit == 4'h8) begin
                            shift_r <= {majority, shift_r[8:1]};
                        end else begin
                            shift_r <= {1'b0, majority, shift_r[7:1]};
                        end
                        sub_r <= 4'h0;
                        if (bit_idx_r == last_bit) begin
                            state_r <= aur_pkg::ST_STOP;
                        end else begin
                            bit_idx_r <= bit_idx_r + 4'h1;
                        end
                    end else begin
                        sub_r <= sub_r + 4'h1;
                    end
                end
                aur_pkg::ST_STOP: begin
                    if (sub_r == aur_pkg::FULL_BIT_TICKS) begin
                        state_r <= aur_pkg::ST_IDLE;
                        sub_r <= 4'h0;
                    end else begin
                        sub_r <= sub_r + 4'h1;
                    end
                end
                default: begin
                    state_r <= aur_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // FIFO storage: data, ninth bit and framing error per entry
    always_ff @(posedge i_clk) begin
        if (push) begin
            // Low stop sample gives a framing error for this character
            fifo_r[wr_ptr_r] <= {!majority, shift_r};
        end
    end

    // FIFO pointers, count and overrun
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
            count_r <= 2'h0;
            overrun_r <= 1'b0;
        end else if (!port_en) begin
            // Port off clears pointers, count and overrun; stored entries are left in place but dropped
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
            count_r <= 2'h0;
            overrun_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
            if (!rx_en) begin
                overrun_r <= 1'b0;
            end else if (stop_done && accept && count_r == 2'h2 && !pop) begin
                // Stored entries stay readable; later characters dropped
                overrun_r <= 1'b1;
            end
        end
    end

    // Framing flag held across receiver disable; follows the head entry, cleared by port off
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            frame_error_flag_hold_r <= 1'b0;
        end else if (!port_en) begin
            frame_error_flag_hold_r <= 1'b0;
        end else if (count_r != 2'h0 || push) begin
            frame_error_flag_hold_r <= (count_r != 2'h0 && !pop) ? head[9]
                : ((count_r == 2'h2) ? fifo_r[~rd_ptr_r][9] : (push ? !majority : frame_error_flag_hold_r));
        end
    end

    // Pending flag, interrupt and pin control outputs
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rx_pending_flag <= 1'b0;
            o_irq <= 1'b0;
            o_rx_pin_oe <= 1'b0;
            o_tx_pin <= 1'b1;
            o_tx_pin_oe <= 1'b0;
        end else begin
            // Next-cycle occupancy, independent of interrupt enables
            o_rx_pending_flag <= rx_en && port_en
                && ((count_r + {1'b0, push} - {1'b0, pop}) != 2'h0);
            o_irq <= rx_en && port_en
                && ((count_r + {1'b0, push} - {1'b0, pop}) != 2'h0)
                && (&irq_ctl_r);
            o_rx_pin_oe <= 1'b0;
            if (port_en) begin
                // Idle mark driven; general latch disconnected
                o_tx_pin <= 1'b1;
                o_tx_pin_oe <= 1'b1;
            end else begin
                o_tx_pin <= i_gpio_latch;
                o_tx_pin_oe <= !i_pin_direction_bit;
            end
        end
    end
endmodule // aur_receiver
